// >>> inc/dfsst_pkg.sv
// Shared constants for the DMA fed synchronous serial transmitter.
// Assumes a 32-bit APB register bus and a byte-wide memory read port.
package dfsst_pkg;

  // ==========================================================
  // Clock and bit rate
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BIT_RATE_BPS = 250_000;
  // Half bit period in pclk cycles, minus one, is the divider value.
  localparam logic [7:0] DIVIDER_RESET = 8'(CLK_HZ / (2 * BIT_RATE_BPS) - 1);

  // ==========================================================
  // Register byte addresses
  localparam logic [11:0] ADDR_HOLDING = 12'h000;
  localparam logic [11:0] ADDR_FORMAT = 12'h004;
  localparam logic [11:0] ADDR_DIVIDER = 12'h008;
  localparam logic [11:0] ADDR_CONTROL = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_IFMODE = 12'h014;
  localparam logic [11:0] ADDR_SRC = 12'h018;
  localparam logic [11:0] ADDR_DST = 12'h01c;
  localparam logic [11:0] ADDR_COUNT = 12'h020;
  localparam logic [11:0] ADDR_DMA_CTRL = 12'h024;
  localparam logic [11:0] ADDR_DMA_ADDRMODE = 12'h028;
  localparam logic [11:0] ADDR_DMA_TRIGGER = 12'h02c;

  // ==========================================================
  // Serial control bit positions
  localparam int CTRL_TX_IRQ_EN = 7;
  localparam int CTRL_RX_IRQ_EN = 6;
  localparam int CTRL_TX_EN = 5;
  localparam int CTRL_RX_EN = 4;
  localparam int CTRL_END_IRQ_EN = 2;

  // Serial status bit positions.
  localparam int ST_HOLDING_EMPTY = 7;
  localparam int ST_RECEIVE_FULL = 6;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAMING = 4;
  localparam int ST_PARITY = 3;
  localparam int ST_TX_END = 2;
  localparam int ST_PEER_READY = 0;

  // DMA control bit positions.
  localparam int DMA_ENABLE = 0;
  localparam int DMA_DONE = 1;

  // Address update modes, two bits each: source in [1:0], destination in [3:2].
  localparam logic [1:0] AMODE_FIXED = 2'h0;
  localparam logic [1:0] AMODE_INC = 2'h1;
  localparam logic [1:0] AMODE_DEC = 2'h2;

  // Trigger select code for the transmit empty request.
  localparam logic [7:0] TRIG_TX_EMPTY = 8'h01;

  // ==========================================================
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h84;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [3:0] ADDRMODE_RESET = 4'h1;
  localparam logic [7:0] TRIGGER_RESET = 8'h01;

  // DMA channel states.
  typedef enum logic [2:0] {
    DFSST_DMA_IDLE = 3'b001,
    DFSST_DMA_READ = 3'b010,
    DFSST_DMA_WRITE = 3'b100
  } dfsst_dma_state_t;

endpackage

// >>> rtl/dfsst_top.sv
// Serial transmitter with double buffered output and its own DMA channel.
// Assumes an APB master on the register side, a memory that answers
// read requests with a one-cycle acknowledge, and a peer receiver that
// samples data on the rising edge of the serial clock driven here.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps

module dfsst_top #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output logic serial_clk_out,
  output logic serial_data_out,
  input wire logic peer_ready_line,
  output logic tx_empty_request
);

  // ==========================================================
  // Declarations
  logic [7:0] transmit_holding_byte_reg;
  logic [7:0] serial_format_select_reg;
  logic [7:0] bit_rate_divider_reg;
  logic [7:0] serial_control_bits_reg;
  logic [7:0] serial_status_flags_reg;
  logic [7:0] serial_status_flags_next;
  logic [7:0] interface_mode_select_reg;
  logic [31:0] dma_source_pointer_reg;
  logic [31:0] dma_destination_pointer_reg;
  logic [31:0] dma_remaining_count_reg;
  logic [1:0] dma_operation_control_reg;
  logic [3:0] dma_addressing_setup_reg;
  logic [7:0] dma_trigger_select_reg;
  logic holding_full_reg;
  logic [7:0] transmit_shifter_reg;
  logic [2:0] bit_idx_reg;
  logic busy_reg;
  logic sclk_reg;
  logic sdo_reg;
  logic [7:0] div_cnt_reg;
  logic peer_go_reg;
  logic tx_en_d_reg;
  logic [7:0] dma_byte_reg;
  dfsst_pkg::dfsst_dma_state_t dma_state_reg;
  logic wr_en;
  logic setup_phase;
  logic sw_holding_wr;
  logic tx_en;
  logic tick;
  logic frame_end;
  logic load_shifter;
  logic dma_start;
  logic dma_write;

  // ==========================================================
  // Helper functions

  // Steps an address by one byte according to its update mode.
  function automatic logic [31:0] next_addr(input logic [31:0] addr, input logic [1:0] mode);
    logic [31:0] res;
    res = addr;
    if (mode == dfsst_pkg::AMODE_INC) begin
      res = addr + 32'h0000_0001;
    end else if (mode == dfsst_pkg::AMODE_DEC) begin
      res = addr - 32'h0000_0001;
    end
    return res;
  endfunction

  // Tells whether a byte address belongs to the register map.
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (addr)
      dfsst_pkg::ADDR_HOLDING, dfsst_pkg::ADDR_FORMAT, dfsst_pkg::ADDR_DIVIDER,
      dfsst_pkg::ADDR_CONTROL, dfsst_pkg::ADDR_STATUS, dfsst_pkg::ADDR_IFMODE,
      dfsst_pkg::ADDR_SRC, dfsst_pkg::ADDR_DST, dfsst_pkg::ADDR_COUNT,
      dfsst_pkg::ADDR_DMA_CTRL, dfsst_pkg::ADDR_DMA_ADDRMODE,
      dfsst_pkg::ADDR_DMA_TRIGGER: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ==========================================================
  // APB handshake

  // Every access completes in its first access cycle.
  assign pready = penable;
  assign setup_phase = psel & ~penable;
  assign wr_en = psel & penable & pwrite & is_mapped(paddr);
  // The DMA channel owns the holding byte in its write cycle.
  assign sw_holding_wr = wr_en & (paddr == dfsst_pkg::ADDR_HOLDING) & ~dma_write;

  // Read data and error answer are captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= dfsst_pkg::WORD_RESET;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= ~is_mapped(paddr);
      prdata <= dfsst_pkg::WORD_RESET;
      if (!pwrite) begin
        // The shifter has no address and never appears here.
        unique case (paddr)
          dfsst_pkg::ADDR_HOLDING: prdata <= {24'h0, transmit_holding_byte_reg};
          dfsst_pkg::ADDR_FORMAT: prdata <= {24'h0, serial_format_select_reg};
          dfsst_pkg::ADDR_DIVIDER: prdata <= {24'h0, bit_rate_divider_reg};
          dfsst_pkg::ADDR_CONTROL: prdata <= {24'h0, serial_control_bits_reg};
          dfsst_pkg::ADDR_STATUS: prdata <= {24'h0, serial_status_flags_reg};
          dfsst_pkg::ADDR_IFMODE: prdata <= {24'h0, interface_mode_select_reg};
          dfsst_pkg::ADDR_SRC: prdata <= dma_source_pointer_reg;
          dfsst_pkg::ADDR_DST: prdata <= dma_destination_pointer_reg;
          dfsst_pkg::ADDR_COUNT: prdata <= dma_remaining_count_reg;
          dfsst_pkg::ADDR_DMA_CTRL: prdata <= {30'h0, dma_operation_control_reg};
          dfsst_pkg::ADDR_DMA_ADDRMODE: prdata <= {28'h0, dma_addressing_setup_reg};
          dfsst_pkg::ADDR_DMA_TRIGGER: prdata <= {24'h0, dma_trigger_select_reg};
          default: prdata <= dfsst_pkg::WORD_RESET;
        endcase
      end
    end
  end

  // ==========================================================
  // Serial configuration registers

  // Format, divider, control and interface mode are plain storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_format_select_reg <= dfsst_pkg::BYTE_RESET;
      bit_rate_divider_reg <= dfsst_pkg::DIVIDER_RESET;
      serial_control_bits_reg <= dfsst_pkg::BYTE_RESET;
      interface_mode_select_reg <= dfsst_pkg::BYTE_RESET;
    end else if (wr_en) begin
      if (paddr == dfsst_pkg::ADDR_FORMAT) begin
        serial_format_select_reg <= pwdata[7:0];
      end
      if (paddr == dfsst_pkg::ADDR_DIVIDER) begin
        bit_rate_divider_reg <= pwdata[7:0];
      end
      if (paddr == dfsst_pkg::ADDR_CONTROL) begin
        serial_control_bits_reg <= pwdata[7:0];
      end
      if (paddr == dfsst_pkg::ADDR_IFMODE) begin
        interface_mode_select_reg <= pwdata[7:0];
      end
    end
  end

  assign tx_en = serial_control_bits_reg[dfsst_pkg::CTRL_TX_EN];
  // Request is a level: high while transmit and its interrupt are enabled and the holding empty flag is set.
  assign tx_empty_request = tx_en & serial_control_bits_reg[dfsst_pkg::CTRL_TX_IRQ_EN]
                          & serial_status_flags_reg[dfsst_pkg::ST_HOLDING_EMPTY];

  // ==========================================================
  // Holding byte

  // Loaded by software or by the DMA channel; full until moved on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_holding_byte_reg <= dfsst_pkg::BYTE_RESET;
      holding_full_reg <= 1'b0;
    end else begin
      if (dma_write) begin
        transmit_holding_byte_reg <= dma_byte_reg;
        holding_full_reg <= 1'b1;
      end else if (sw_holding_wr) begin
        transmit_holding_byte_reg <= pwdata[7:0];
        holding_full_reg <= 1'b1;
      end else if (load_shifter) begin
        holding_full_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Status flags

  // Hardware sets win over software clears in the same cycle.
  always_comb begin
    serial_status_flags_next = serial_status_flags_reg;
    if (wr_en && paddr == dfsst_pkg::ADDR_STATUS) begin
      // Writing zero clears a flag, writing one leaves it alone.
      serial_status_flags_next[7:2] = serial_status_flags_reg[7:2] & pwdata[7:2];
    end
    if (dma_write) begin
      serial_status_flags_next[dfsst_pkg::ST_HOLDING_EMPTY] = 1'b0;
    end
    if (load_shifter || (tx_en && !tx_en_d_reg)) begin
      serial_status_flags_next[dfsst_pkg::ST_HOLDING_EMPTY] = 1'b1;
    end
    if (load_shifter) begin
      serial_status_flags_next[dfsst_pkg::ST_TX_END] = 1'b0;
    end
    if (frame_end && !load_shifter) begin
      serial_status_flags_next[dfsst_pkg::ST_TX_END] = 1'b1;
    end
    serial_status_flags_next[1] = 1'b0;
    serial_status_flags_next[dfsst_pkg::ST_PEER_READY] = peer_ready_line;
  end

  // Status register and the enable edge detector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_status_flags_reg <= dfsst_pkg::STATUS_RESET;
      tx_en_d_reg <= 1'b0;
    end else begin
      serial_status_flags_reg <= serial_status_flags_next;
      tx_en_d_reg <= tx_en;
    end
  end

  // ==========================================================
  // Peer ready gate

  // Once the peer reads high with transmit enabled, the session may run.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peer_go_reg <= 1'b0;
    end else if (!tx_en) begin
      peer_go_reg <= 1'b0;
    end else if (peer_ready_line) begin
      peer_go_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Frame engine

  assign tick = (div_cnt_reg == 8'h00);
  assign frame_end = busy_reg & tick & sclk_reg & (bit_idx_reg == 3'h7);
  // Reload happens when idle or exactly at the end of the last bit.
  assign load_shifter = holding_full_reg & tx_en & peer_go_reg
                      & (~busy_reg | frame_end);

  // Half bit timer: each half bit lasts divider plus one cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= dfsst_pkg::DIVIDER_RESET;
    end else if (load_shifter || !busy_reg || tick) begin
      div_cnt_reg <= bit_rate_divider_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg - 8'h01;
    end
  end

  // Clock idles high; data changes on falling edges, lsb first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_shifter_reg <= dfsst_pkg::BYTE_RESET;
      bit_idx_reg <= 3'h0;
      busy_reg <= 1'b0;
      sclk_reg <= 1'b1;
      sdo_reg <= 1'b1;
    end else if (load_shifter) begin
      transmit_shifter_reg <= transmit_holding_byte_reg;
      sdo_reg <= transmit_holding_byte_reg[0];
      bit_idx_reg <= 3'h0;
      busy_reg <= 1'b1;
      sclk_reg <= 1'b0;
    end else if (frame_end) begin
      busy_reg <= 1'b0;
      sclk_reg <= 1'b1;
      sdo_reg <= 1'b1;
    end else if (busy_reg && tick) begin
      sclk_reg <= ~sclk_reg;
      if (sclk_reg) begin
        transmit_shifter_reg <= {1'b0, transmit_shifter_reg[7:1]};
        sdo_reg <= transmit_shifter_reg[1];
        bit_idx_reg <= bit_idx_reg + 3'h1;
      end
    end
  end

  assign serial_clk_out = sclk_reg;
  assign serial_data_out = sdo_reg;

  // ==========================================================
  // DMA channel

  assign dma_start = (dma_state_reg == dfsst_pkg::DFSST_DMA_IDLE)
                   & dma_operation_control_reg[dfsst_pkg::DMA_ENABLE]
                   & (dma_trigger_select_reg == dfsst_pkg::TRIG_TX_EMPTY)
                   & (dma_remaining_count_reg != 32'h0000_0000)
                   & tx_empty_request;
  assign dma_write = (dma_state_reg == dfsst_pkg::DFSST_DMA_WRITE);
  assign mem_req = (dma_state_reg == dfsst_pkg::DFSST_DMA_READ);
  assign mem_addr = dma_source_pointer_reg;

  // One read, one write per request, then wait for the next request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_state_reg <= dfsst_pkg::DFSST_DMA_IDLE;
      dma_byte_reg <= dfsst_pkg::BYTE_RESET;
    end else begin
      unique case (dma_state_reg)
        dfsst_pkg::DFSST_DMA_IDLE: begin
          if (dma_start) begin
            dma_state_reg <= dfsst_pkg::DFSST_DMA_READ;
          end
        end
        dfsst_pkg::DFSST_DMA_READ: begin
          if (mem_ack) begin
            dma_byte_reg <= mem_rdata;
            dma_state_reg <= dfsst_pkg::DFSST_DMA_WRITE;
          end
        end
        dfsst_pkg::DFSST_DMA_WRITE: begin
          dma_state_reg <= dfsst_pkg::DFSST_DMA_IDLE;
        end
        default: begin
          dma_state_reg <= dfsst_pkg::DFSST_DMA_IDLE;
        end
      endcase
    end
  end

  // Pointers and count: software writes, hardware updates win.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_source_pointer_reg <= dfsst_pkg::WORD_RESET;
      dma_destination_pointer_reg <= dfsst_pkg::WORD_RESET;
      dma_remaining_count_reg <= dfsst_pkg::WORD_RESET;
    end else if (dma_write) begin
      dma_source_pointer_reg <= next_addr(dma_source_pointer_reg,
                                          dma_addressing_setup_reg[1:0]);
      dma_destination_pointer_reg <= next_addr(dma_destination_pointer_reg,
                                               dma_addressing_setup_reg[3:2]);
      dma_remaining_count_reg <= dma_remaining_count_reg - 32'h0000_0001;
    end else if (wr_en) begin
      if (paddr == dfsst_pkg::ADDR_SRC) begin
        dma_source_pointer_reg <= pwdata;
      end
      if (paddr == dfsst_pkg::ADDR_DST) begin
        dma_destination_pointer_reg <= pwdata;
      end
      if (paddr == dfsst_pkg::ADDR_COUNT) begin
        dma_remaining_count_reg <= pwdata;
      end
    end
  end

  // Enable falls and done rises after the last byte of the block.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_operation_control_reg <= 2'h0;
      dma_addressing_setup_reg <= dfsst_pkg::ADDRMODE_RESET;
      dma_trigger_select_reg <= dfsst_pkg::TRIGGER_RESET;
    end else begin
      if (wr_en && paddr == dfsst_pkg::ADDR_DMA_CTRL) begin
        dma_operation_control_reg[dfsst_pkg::DMA_ENABLE] <= pwdata[dfsst_pkg::DMA_ENABLE];
        dma_operation_control_reg[dfsst_pkg::DMA_DONE] <=
          dma_operation_control_reg[dfsst_pkg::DMA_DONE] & pwdata[dfsst_pkg::DMA_DONE];
      end
      if (dma_write && dma_remaining_count_reg == 32'h0000_0001) begin
        dma_operation_control_reg[dfsst_pkg::DMA_ENABLE] <= 1'b0;
        dma_operation_control_reg[dfsst_pkg::DMA_DONE] <= 1'b1;
      end
      if (wr_en && paddr == dfsst_pkg::ADDR_DMA_ADDRMODE) begin
        dma_addressing_setup_reg <= pwdata[3:0];
      end
      if (wr_en && paddr == dfsst_pkg::ADDR_DMA_TRIGGER) begin
        dma_trigger_select_reg <= pwdata[7:0];
      end
    end
  end

endmodule

// >>> test/dfsst_top_properties.sv
// Checker for the transmitter top: APB answer, DMA read port and serial pins.
// Assumes it is bound to dfsst_top and sees only that module's ports.
`timescale 1ns/1ps
module dfsst_top_properties #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic serial_clk_out,
  input wire logic serial_data_out,
  input wire logic peer_ready_line
);
  // ==========================================================
  // Helper state
  logic wr;
  logic [7:0] div_q;
  logic txen_q;
  logic go_q;
  logic [15:0] cnt_q;
  logic sclk_d;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A write commits at the access edge.
  assign wr = psel && penable && pwrite && pready;

  // Mirrors the divider, the transmit enable and the latched peer permission.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= dfsst_pkg::DIVIDER_RESET;
      txen_q <= 1'b0;
      go_q <= 1'b0;
    end else if (wr && paddr == dfsst_pkg::ADDR_CONTROL) begin
      txen_q <= pwdata[dfsst_pkg::CTRL_TX_EN];
      go_q <= go_q && pwdata[dfsst_pkg::CTRL_TX_EN];
    end else begin
      if (wr && paddr == dfsst_pkg::ADDR_DIVIDER) begin
        div_q <= pwdata[7:0];
      end
      go_q <= go_q || (txen_q && peer_ready_line);
    end
  end

  // Counts cycles since the serial clock last changed level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      sclk_d <= 1'b1;
    end else begin
      sclk_d <= serial_clk_out;
      if (serial_clk_out != sclk_d) begin
        cnt_q <= 16'h0000;
      end else if (cnt_q != 16'hffff) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Sequences and assertions
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ack;
    mem_req && mem_ack;
  endsequence

  AST_PREADY: assert property (s_setup ##1 (psel && penable) |-> pready)
    else $error("no ready in access cycle");
  AST_UNMAPPED: assert property (psel && penable && paddr >= 12'h030 |-> pslverr)
    else $error("unmapped access without error");
  AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("read request dropped or moved");
  AST_REQ_DROP: assert property (s_ack |=> !mem_req)
    else $error("read request outlived answer");
  AST_SRC_STEP: assert property (s_ack |-> ##2 mem_addr == $past(mem_addr, 2) + 32'h1)
    else $error("source pointer did not step");
  AST_LOW_HALF: assert property ($rose(serial_clk_out) |-> cnt_q == {8'h00, div_q})
    else $error("serial clock low half wrong");
  AST_DATA_HOLD: assert property ($rose(serial_clk_out) ##1 serial_clk_out |->
    $stable(serial_data_out))
    else $error("data moved in high half");
  AST_PEER_GATE: assert property ($fell(serial_clk_out) |-> go_q)
    else $error("shifting without peer ready");
  AST_IDLE_HIGH: assert property (serial_clk_out && !$rose(serial_clk_out) &&
    cnt_q >= {8'h00, div_q} |-> serial_data_out)
    else $error("idle line not high");
endmodule

bind dfsst_top dfsst_top_properties #(.ADDR_W(ADDR_W)) u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .pslverr(pslverr),
  .mem_req(mem_req),
  .mem_addr(mem_addr),
  .mem_ack(mem_ack),
  .serial_clk_out(serial_clk_out),
  .serial_data_out(serial_data_out),
  .peer_ready_line(peer_ready_line)
);

// >>> test/dfsst_peer.sv
// Partner model: the byte memory behind the DMA port and the peer receiver.
// Assumes the bench supplies the read latency and checks received bytes.
`timescale 1ns/1ps
module dfsst_peer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] lat,
  output logic [7:0] mem_rdata,
  output logic mem_ack,
  input wire logic serial_clk_out,
  input wire logic serial_data_out,
  output logic [7:0] rx_byte,
  output logic [7:0] rx_count
);
  // ==========================================================
  // Memory
  logic [1:0] wait_q;
  logic [7:0] sr_q;
  logic [2:0] bit_q;

  // Answers a read after lat cycles with the address folded by 5a.
  // Between answers the data lines toggle every cycle between the last byte and its inverse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      mem_rdata <= 8'h00;
    end else if (mem_req && !mem_ack && wait_q >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_addr[7:0] ^ 8'h5a;
    end else begin
      mem_ack <= 1'b0;
      wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end

  // ==========================================================
  // Receiver
  // Shifts on the rising serial clock, least significant bit first.
  always_ff @(posedge serial_clk_out or negedge presetn) begin
    if (!presetn) begin
      sr_q <= 8'h00;
      bit_q <= 3'h0;
      rx_byte <= 8'h00;
      rx_count <= 8'h00;
    end else begin
      sr_q <= {serial_data_out, sr_q[7:1]};
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        rx_byte <= {serial_data_out, sr_q[7:1]};
        rx_count <= rx_count + 8'h01;
      end
    end
  end
endmodule

// >>> test/dfsst_top_tb_top.sv
// Testbench: registers over APB, then a 128-byte DMA fed serial block.
// Assumes the partner model answers memory reads and receives frames.
`timescale 1ns/1ps
module dfsst_top_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic mem_req, mem_ack, sclk, sdo, peer_rdy, tx_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, base, dst;
  logic [7:0] mem_rdata, rx_byte, rx_count, exp8;
  logic [1:0] lat;
  logic [32:0] got;
  int errors, tests_run, cycles, seed;
  logic [32:0] rd_q[$];
  logic [7:0] by_q[$];
  logic [43:0] rst_tab [12] = '{44'h010_00000084, 44'h008_00000013, 44'h00c_00000000,
    44'h004_00000000, 44'h014_00000000, 44'h018_00000000, 44'h01c_00000000,
    44'h020_00000000, 44'h024_00000000, 44'h028_00000001, 44'h02c_00000001,
    44'h000_00000000};

  dfsst_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .serial_clk_out(sclk), .serial_data_out(sdo),
    .peer_ready_line(peer_rdy), .tx_empty_request(tx_req));
  dfsst_peer u_peer (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .lat(lat), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .serial_clk_out(sclk), .serial_data_out(sdo), .rx_byte(rx_byte), .rx_count(rx_count));

  // ==========================================================
  // Tasks
  task automatic cmp_word(input logic [32:0] exp, input logic [32:0] act);
    tests_run++;
    if (act !== exp) begin
      errors++;
      $display("BAD %0t word exp %h got %h", $time, exp, act);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] act);
    tests_run++;
    if (act !== exp) begin
      errors++;
      $display("BAD %0t byte exp %h got %h", $time, exp, act);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    rd_q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic summarize;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // Clock, random latency, watchdog and monitors
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Memory latency changes every cycle so reads come back fast and slow.
  always @(posedge pclk) lat <= 2'($random(seed));
  // A hang is cut short after a fixed budget of cycles.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      summarize();
    end
  end
  // Read data and error are compared at the accepting edge.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      got = rd_q.pop_front();
      cmp_word(got, {pslverr, prdata});
    end
  end
  // Each received byte is compared with the oldest expected one.
  always @(rx_count) begin
    if (presetn === 1'b1) begin
      exp8 = by_q.size() != 0 ? by_q.pop_front() : ~rx_byte;
      cmp_byte(exp8, rx_byte);
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 67637;
    errors = 0;
    tests_run = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, peer_rdy} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_tab[i]) rd(rst_tab[i][43:32], {1'b0, rst_tab[i][31:0]});
    rd(12'h030, {1'b1, 32'h0});
    dst = $random(seed);
    apb(1'b1, 12'h004, dst);
    rd(12'h004, {25'h0, dst[7:0]});
    apb(1'b1, 12'h014, dst);
    rd(12'h014, {25'h0, dst[7:0]});
    apb(1'b1, 12'h01c, dst);
    rd(12'h01c, {1'b0, dst});
    apb(1'b1, 12'h000, 32'h1a5);
    rd(12'h000, {25'h0, 8'ha5});
    apb(1'b1, 12'h010, 32'h0);
    rd(12'h010, 33'h0);
    apb(1'b1, 12'h010, 32'hff);
    rd(12'h010, 33'h0);
    // Block setup: fast divider, random source, 128 bytes, DMA on.
    base = $random(seed);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h018, base);
    apb(1'b1, 12'h020, 32'd128);
    apb(1'b1, 12'h024, 32'h1);
    for (int i = 0; i < 128; i++) by_q.push_back(8'(base + i) ^ 8'h5a);
    apb(1'b1, 12'h00c, 32'ha0);
    repeat (60) @(posedge pclk);
    cmp_byte(8'h01, {7'h0, sclk});
    cmp_byte(8'h00, {7'h0, tx_req});
    peer_rdy <= 1'b1;
    while (by_q.size() != 0) @(posedge pclk);
    repeat (20) @(posedge pclk);
    rd(12'h020, 33'h0);
    rd(12'h018, {1'b0, base + 32'd128});
    rd(12'h01c, {1'b0, dst});
    rd(12'h024, 33'h2);
    rd(12'h010, 33'h85);
    cmp_byte(8'h01, {7'h0, sclk});
    cmp_byte(8'h01, {7'h0, tx_req});
    @(posedge pclk);
    summarize();
  end
endmodule
